/* logic/hsg_pkg.sv */
// Package: constants, register map and encodings of the halt-mode gating block
package hsg_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0] HSG_CTRL_OFF   = 12'h000;
	localparam logic [11:0] HSG_SRC_OFF    = 12'h004;
	localparam logic [11:0] HSG_IRQ_OFF    = 12'h008;
	localparam logic [11:0] HSG_STAT_OFF   = 12'h00C;
	localparam logic [11:0] HSG_GATE_OFF   = 12'h010;
	localparam logic [11:0] HSG_PORT_OFF   = 12'h014;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int HSG_CTRL_HALT_BIT   = 0;
	localparam int HSG_CTRL_MAIN_STOP  = 1;
	localparam int HSG_CTRL_INT_STOP   = 2;
	localparam int HSG_CTRL_IE_BIT     = 3;
	localparam int HSG_CTRL_SUB_CPU    = 4;

	// ----------------------------------------------------------------
	// Clock source selection fields
	// ----------------------------------------------------------------
	localparam int HSG_SRC_CNT_A_EXT   = 0;
	localparam int HSG_SRC_CNT_B_EXT   = 1;
	localparam int HSG_SRC_ITA_FROM_A  = 2;
	localparam int HSG_SRC_ITB_MAIN    = 3;
	localparam int HSG_SRC_ITB_INT128  = 4;
	localparam int HSG_SRC_WATCH_SUB   = 5;
	localparam int HSG_SRC_UART_FROM_A = 6;
	localparam int HSG_SRC_CSA_EXT     = 7;
	localparam int HSG_SRC_CSB_EXT     = 8;
	localparam int HSG_SRC_CNT_A_RUN   = 9;

	// ----------------------------------------------------------------
	// Clock enable vector bit positions
	// ----------------------------------------------------------------
	localparam int HSG_G_CPU      = 0;
	localparam int HSG_G_WIDE     = 1;
	localparam int HSG_G_CNT_A    = 2;
	localparam int HSG_G_CNT_B    = 3;
	localparam int HSG_G_ITA      = 4;
	localparam int HSG_G_ITB      = 5;
	localparam int HSG_G_WATCH    = 6;
	localparam int HSG_G_WDOG     = 7;
	localparam int HSG_G_UART     = 8;
	localparam int HSG_G_CSA      = 9;
	localparam int HSG_G_CSB      = 10;
	localparam int HSG_G_ADC_MUL  = 11;
	localparam int HSG_G_CLKMON   = 12;
	localparam int HSG_G_ALWAYS   = 13;
	localparam int HSG_GATE_W     = 14;

	// ----------------------------------------------------------------
	// Reset values and release waits (CPU clock cycles)
	// ----------------------------------------------------------------
	localparam logic [31:0] HSG_CTRL_RST = 32'h0000_0010;
	localparam logic [31:0] HSG_SRC_RST  = 32'h0000_0000;
	localparam int HSG_WAIT_VECT   = 8;
	localparam int HSG_WAIT_RESUME = 2;
	localparam int HSG_PORT_W      = 8;

	typedef enum logic [1:0] {
		HSG_RUN,
		HSG_HALTED,
		HSG_WAKE
	} hsg_state_e;

endpackage

/* logic/hsg_gate_table.sv */
// Module: combinational halt-mode peripheral gating table
`timescale 1ns/1ns
module hsg_gate_table
	import hsg_pkg::*;
(
	input  wire logic                halted,
	input  wire logic                main_run,
	input  wire logic                int_run,
	input  wire logic                wdog_fixed,
	input  wire logic [9:0]          src_sel,
	output logic      [HSG_GATE_W-1:0] gate_en
);

	always_comb begin
		gate_en = '1;
		gate_en[HSG_G_CLKMON] = main_run && int_run;
		gate_en[HSG_G_WDOG]   = int_run;
		if (halted) begin
			gate_en[HSG_G_CPU]  = 1'b0;
			gate_en[HSG_G_WDOG] = wdog_fixed && int_run;
			if (!main_run) begin
				gate_en[HSG_G_WIDE]    = 1'b0;
				gate_en[HSG_G_CNT_A]   = src_sel[HSG_SRC_CNT_A_EXT];
				gate_en[HSG_G_CNT_B]   = src_sel[HSG_SRC_CNT_B_EXT];
				gate_en[HSG_G_ITA]     = src_sel[HSG_SRC_ITA_FROM_A]
					&& src_sel[HSG_SRC_CNT_A_RUN]
					&& src_sel[HSG_SRC_CNT_A_EXT];
				gate_en[HSG_G_WATCH]   = src_sel[HSG_SRC_WATCH_SUB];
				gate_en[HSG_G_UART]    = src_sel[HSG_SRC_UART_FROM_A]
					&& src_sel[HSG_SRC_CNT_A_RUN]
					&& src_sel[HSG_SRC_CNT_A_EXT];
				gate_en[HSG_G_CSA]     = src_sel[HSG_SRC_CSA_EXT];
				gate_en[HSG_G_CSB]     = src_sel[HSG_SRC_CSB_EXT];
				gate_en[HSG_G_ADC_MUL] = 1'b0;
			end
			// Second interval timer depends on both oscillators
			case ({main_run, int_run})
				2'b11:   gate_en[HSG_G_ITB] = 1'b1;
				2'b10:   gate_en[HSG_G_ITB] = src_sel[HSG_SRC_ITB_MAIN];
				2'b01:   gate_en[HSG_G_ITB] = src_sel[HSG_SRC_ITB_INT128];
				default: gate_en[HSG_G_ITB] = 1'b0;
			endcase
		end
		gate_en[HSG_G_ALWAYS] = 1'b1;
	end

endmodule

/* logic/hsg_top.sv */
// Module: halt-mode clock gating controller with APB register access
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ns
//
// Behaviour
// - Gating table applies when halting while the CPU runs on subsystem clock.
// - While halted the CPU clock is gated off in every oscillator case.
// - Port output latches keep their pre-halt value throughout halt.
// - Wide counters count during halt only while main oscillator runs.
// - Byte counters need main oscillator or their external count input.
// - First interval timer needs main oscillator or running counter A output.
// - Second interval timer selection depends on main and internal oscillator.
// - Watch timer needs main oscillator or subsystem clock as source.
// - Watchdog runs in halt only if internal oscillator is non-stoppable.
// - Async serial units need main oscillator or running counter A baud.
// - Clocked serial units need main oscillator or their external clock pin.
// - Unmasked interrupt ends halt; resume or vectored service per enable.
// - Release waits 8 clocks before servicing, 2 before resuming.
module hsg_top
	import hsg_pkg::*;
#(
	parameter int NUM_IRQ = 8
)(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  wdog_fixed,
	input  wire logic [NUM_IRQ-1:0]    irq_req,
	input  wire logic [HSG_PORT_W-1:0] port_in,
	output logic      [HSG_PORT_W-1:0] port_out,
	output logic      [HSG_GATE_W-1:0] clk_en,
	output logic                       halted,
	output logic                       wake_vector,
	output logic                       wake_resume
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [31:0]           ctrl_reg,   ctrl_next;
	logic [31:0]           src_reg,    src_next;
	logic [NUM_IRQ-1:0]    mask_reg,   mask_next;
	logic [HSG_PORT_W-1:0] port_reg,   port_next;
	logic [31:0]           rdata_reg,  rdata_next;
	logic                  ready_reg,  ready_next;
	logic                  err_reg,    err_next;
	logic [3:0]            wait_reg,   wait_next;
	logic                  vect_reg,   vect_next;
	logic                  wvec_reg,   wvec_next;
	logic                  wres_reg,   wres_next;
	logic [HSG_GATE_W-1:0] en_reg;
	logic                  halt_reg;
	hsg_state_e            state_reg,  state_next;

	logic [HSG_GATE_W-1:0] gate_en;
	logic                  main_run;
	logic                  int_run;
	logic                  is_halt;
	logic                  wake_req;
	logic                  acc;
	logic                  wr;

	assign main_run = !ctrl_reg[HSG_CTRL_MAIN_STOP];
	assign int_run  = !(ctrl_reg[HSG_CTRL_INT_STOP] && !wdog_fixed);
	// Release wait counts as halted too, so the core stays gated until it ends
	assign is_halt  = (state_reg != HSG_RUN);
	assign wake_req = |(irq_req & ~mask_reg);
	assign acc      = psel && penable && !ready_reg;
	assign wr       = acc && pwrite;

	function automatic logic hit(input logic [11:0] a,
		input logic [11:0] off);
		hit = (a == off);
	endfunction

	// ----------------------------------------------------------------
	// Gating table
	// ----------------------------------------------------------------
	hsg_gate_table u_table (
		.halted     (is_halt),
		.main_run   (main_run),
		.int_run    (int_run),
		.wdog_fixed (wdog_fixed),
		.src_sel    (src_reg[9:0]),
		.gate_en    (gate_en)
	);

	// ----------------------------------------------------------------
	// Halt sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		wait_next  = wait_reg;
		vect_next  = vect_reg;
		wvec_next  = 1'b0;
		wres_next  = 1'b0;
		case (state_reg)
			HSG_RUN: begin
				// Halt gating only defined for subsystem clock operation
				if (wr && hit(paddr, HSG_CTRL_OFF)
					&& pwdata[HSG_CTRL_HALT_BIT]
					&& ctrl_reg[HSG_CTRL_SUB_CPU]) begin
					state_next = HSG_HALTED;
				end
			end
			HSG_HALTED: begin
				if (wake_req) begin
					state_next = HSG_WAKE;
					vect_next  = ctrl_reg[HSG_CTRL_IE_BIT];
					wait_next  = vect_next ? 4'(HSG_WAIT_VECT - 1)
						: 4'(HSG_WAIT_RESUME - 1);
				end
			end
			HSG_WAKE: begin
				if (wait_reg == 4'h0) begin
					state_next = HSG_RUN;
					wvec_next  = vect_reg;
					wres_next  = !vect_reg;
				end else begin
					wait_next = wait_reg - 4'h1;
				end
			end
			default: state_next = HSG_RUN;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers and APB
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_next  = ctrl_reg;
		src_next   = src_reg;
		mask_next  = mask_reg;
		port_next  = port_reg;
		rdata_next = rdata_reg;
		err_next   = 1'b0;
		ready_next = acc;
		if (acc) begin
			err_next = !(hit(paddr, HSG_CTRL_OFF) || hit(paddr, HSG_SRC_OFF)
				|| hit(paddr, HSG_IRQ_OFF) || hit(paddr, HSG_STAT_OFF)
				|| hit(paddr, HSG_GATE_OFF) || hit(paddr, HSG_PORT_OFF));
			rdata_next = 32'h0000_0000;
			if (pwrite) begin
				if (hit(paddr, HSG_CTRL_OFF)) begin
					ctrl_next = {27'h000_0000, pwdata[4:1], 1'b0};
				end
				if (hit(paddr, HSG_SRC_OFF)) begin
					src_next = {22'h00_0000, pwdata[9:0]};
				end
				if (hit(paddr, HSG_IRQ_OFF)) begin
					mask_next = pwdata[NUM_IRQ-1:0];
				end
				// Latches frozen while halted; CPU cannot write anyway
				if (hit(paddr, HSG_PORT_OFF) && state_reg == HSG_RUN) begin
					port_next = pwdata[HSG_PORT_W-1:0];
				end
			end else begin
				if (hit(paddr, HSG_CTRL_OFF)) begin
					rdata_next = ctrl_reg;
				end
				if (hit(paddr, HSG_SRC_OFF)) begin
					rdata_next = src_reg;
				end
				if (hit(paddr, HSG_IRQ_OFF)) begin
					rdata_next[NUM_IRQ-1:0] = mask_reg;
				end
				if (hit(paddr, HSG_STAT_OFF)) begin
					rdata_next[1:0] = state_reg;
					rdata_next[2]   = main_run;
					rdata_next[3]   = int_run;
					rdata_next[4]   = wake_req;
				end
				if (hit(paddr, HSG_GATE_OFF)) begin
					rdata_next[HSG_GATE_W-1:0] = en_reg;
				end
				if (hit(paddr, HSG_PORT_OFF)) begin
					rdata_next[HSG_PORT_W-1:0] = port_in;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg  <= HSG_CTRL_RST;
			src_reg   <= HSG_SRC_RST;
			mask_reg  <= '1;
			port_reg  <= '0;
			rdata_reg <= 32'h0000_0000;
			ready_reg <= 1'b0;
			err_reg   <= 1'b0;
			wait_reg  <= 4'h0;
			vect_reg  <= 1'b0;
			wvec_reg  <= 1'b0;
			wres_reg  <= 1'b0;
			en_reg    <= '1;
			halt_reg  <= 1'b0;
			state_reg <= HSG_RUN;
		end else begin
			ctrl_reg  <= ctrl_next;
			src_reg   <= src_next;
			mask_reg  <= mask_next;
			port_reg  <= port_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			err_reg   <= err_next;
			wait_reg  <= wait_next;
			vect_reg  <= vect_next;
			wvec_reg  <= wvec_next;
			wres_reg  <= wres_next;
			en_reg    <= gate_en;
			halt_reg  <= (state_next != HSG_RUN);
			state_reg <= state_next;
		end
	end

	assign prdata      = rdata_reg;
	assign pready      = ready_reg;
	assign pslverr     = err_reg;
	assign port_out    = port_reg;
	assign clk_en      = en_reg;
	assign halted      = halt_reg;
	assign wake_vector = wvec_reg;
	assign wake_resume = wres_reg;

endmodule

/* bench/hsg_top_asserts.sv */
// Checker: port-level assertions of the halt gating block
`timescale 1ns/1ns
module hsg_top_asserts
	import hsg_pkg::*;
(
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  penable,
	input wire logic                  pready,
	input wire logic                  wdog_fixed,
	input wire logic [HSG_PORT_W-1:0] port_out,
	input wire logic [HSG_GATE_W-1:0] clk_en,
	input wire logic                  halted,
	input wire logic                  wake_vector,
	input wire logic                  wake_resume
);
	// ------------------------------------------------------------
	// Helper: halted for two edges, so the registered enables settled
	// ------------------------------------------------------------
	logic held_reg;
	logic hh;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) held_reg <= 1'b0;
		else held_reg <= halted;
	end
	assign hh = halted && held_reg;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_cpu_gated: assert property (hh |-> !clk_en[HSG_G_CPU])
		else $error("cpu clock on while halted");
	a_port_hold: assert property (hh |-> $stable(port_out))
		else $error("port latch moved while halted");
	a_wdog_option: assert property (hh |-> clk_en[HSG_G_WDOG] == wdog_fixed)
		else $error("watchdog enable wrong in halt");
	a_main_tie: assert property (hh |-> clk_en[HSG_G_WIDE] == clk_en[HSG_G_ADC_MUL])
		else $error("wide counter and converter disagree");
	a_main_all_on: assert property (hh && clk_en[HSG_G_WIDE] |->
		&clk_en[HSG_G_CSB:HSG_G_CNT_A] || !clk_en[HSG_G_WDOG])
		else $error("peripheral off with main oscillator running");
	a_clkmon_main: assert property (hh && clk_en[HSG_G_CLKMON] |-> clk_en[HSG_G_WIDE])
		else $error("clock monitor on without main oscillator");
	a_always_on: assert property (hh |-> clk_en[HSG_G_ALWAYS])
		else $error("always-on group gated");
	a_vector_wait: assert property (wake_vector |-> $past(halted, 8) && !halted && !wake_resume)
		else $error("vectored release timing wrong");
	a_resume_wait: assert property (wake_resume |-> $past(halted, 2) && !halted)
		else $error("resume release timing wrong");
	a_ready_pulse: assert property (pready |-> $past(penable) ##1 !pready)
		else $error("pready not a single answer pulse");
endmodule
bind hsg_top hsg_top_asserts i_chk (.pclk(pclk), .presetn(presetn),
	.penable(penable), .pready(pready), .wdog_fixed(wdog_fixed),
	.port_out(port_out), .clk_en(clk_en), .halted(halted),
	.wake_vector(wake_vector), .wake_resume(wake_resume));

/* bench/testbench.sv */
// Testbench: halt entry, gating table, port hold and wake-up
`timescale 1ns/1ns
module testbench;
	import hsg_pkg::*;
	logic                  pclk, presetn, psel, penable, pwrite, wdog_fixed;
	logic                  pready, pslverr, halted, wake_vector, wake_resume;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata, rd;
	logic [7:0]            irq_req, port_in, port_out;
	logic [HSG_GATE_W-1:0] clk_en;
	logic [1:0]            seen;
	int                    n_fail, num_checks;
	hsg_top #(.NUM_IRQ(8)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .wdog_fixed, .irq_req,
		.port_in, .port_out, .clk_en, .halted, .wake_vector, .wake_resume);
	always #50 pclk = ~pclk;
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	// Waits for pready; the idle edge afterwards keeps psel single-driven
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			$display("[ERR] pready expected 1 seen timeout");
			give_verdict();
		end
		rd = prdata;
		seen[0] = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wake(input logic [7:0] irq);
		int n;
		irq_req <= irq;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((wake_vector | wake_resume) !== 1'b1 && n < 40);
		seen = {wake_vector, wake_resume};
		chk("halted after release", 0, halted);
		irq_req <= 8'h00;
		if (n >= 40) begin
			n_fail++;
			$display("[ERR] wake pulse expected 1 seen timeout");
			give_verdict();
		end
	endtask
	function automatic logic [13:0] exp_gate(input logic m, i, wf,
		input logic [9:0] s);
		logic [13:0] g;
		g = '0;
		g[HSG_G_WIDE] = m;
		g[HSG_G_CNT_A] = m | s[0];
		g[HSG_G_CNT_B] = m | s[1];
		g[HSG_G_ITA] = m | (s[2] & s[9] & s[0]);
		g[HSG_G_ITB] = (m & i) | (m & s[3]) | (i & s[4]);
		g[HSG_G_WATCH] = m | s[5];
		g[HSG_G_WDOG] = wf;
		g[HSG_G_UART] = m | (s[6] & s[9] & s[0]);
		g[HSG_G_CSA] = m | s[7];
		g[HSG_G_CSB] = m | s[8];
		g[HSG_G_ADC_MUL] = m;
		g[HSG_G_CLKMON] = m & i;
		g[HSG_G_ALWAYS] = 1'b1;
		return g;
	endfunction
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		apb(0, HSG_CTRL_OFF, 0);
		chk("ctrl reset", HSG_CTRL_RST, rd);
		apb(0, HSG_SRC_OFF, 0);
		chk("src reset", HSG_SRC_RST, rd);
		apb(0, HSG_GATE_OFF, 0);
		chk("gate reset", 32'h0000_3FFF, rd);
		apb(0, 12'h020, 0);
		chk("unmapped error", 1, seen[0]);
		$display("reset test done");
	endtask
	task automatic t_refuse;
		apb(1, HSG_CTRL_OFF, 32'h0000_0000);
		apb(1, HSG_CTRL_OFF, 32'h0000_0001);
		chk("halt off main cpu clock", 0, halted);
		apb(0, HSG_CTRL_OFF, 0);
		chk("ctrl halt bit reads", 0, rd[0]);
		apb(1, HSG_CTRL_OFF, 32'h0000_0010);
		$display("refuse test done");
	endtask
	task automatic t_port;
		apb(1, HSG_IRQ_OFF, 32'h0000_00FE);
		apb(1, HSG_PORT_OFF, 32'h0000_00A5);
		apb(0, HSG_PORT_OFF, 0);
		chk("port pins", 32'h0000_003C, rd);
		apb(1, HSG_CTRL_OFF, 32'h0000_0011);
		irq_req <= 8'h02;
		apb(1, HSG_PORT_OFF, 32'h0000_005A);
		repeat (20) @(posedge pclk);
		chk("masked irq keeps halt", 1, halted);
		chk("port latch held", 32'h0000_00A5, port_out);
		wake(8'h03);
		chk("resume pulse", 2'b01, seen);
		$display("port test done");
	endtask
	task automatic t_gating;
		logic [9:0] s;
		logic       ie;
		for (int k = 0; k < 16; k++) begin
			s = k[3] ? 10'h3FF : 10'h000;
			ie = k[0] ^ k[3];
			wdog_fixed <= k[2];
			apb(1, HSG_SRC_OFF, {22'h0, s});
			apb(1, HSG_CTRL_OFF, {27'h0, 1'b1, ie, k[1], k[0], 1'b1});
			repeat (3) @(posedge pclk);
			chk("halted", 1, halted);
			chk("clk_en", exp_gate(!k[0], !(k[1] & !k[2]), k[2], s), clk_en);
			wake(8'h01);
			chk("release kind", {ie, !ie}, seen);
		end
		$display("gating test done");
	endtask
	initial begin
		pclk = 0;
		presetn = 0;
		{psel, penable, pwrite, wdog_fixed} = '0;
		paddr = '0;
		pwdata = '0;
		irq_req = '0;
		port_in = 8'h3C;
		n_fail = 0;
		num_checks = 0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_refuse();
		t_port();
		t_gating();
		give_verdict();
	end
endmodule
